// >>> hdl/rxrtp_device.sv
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
// receive connection classifier, one connection
module rxrtp_device
  import rxrtp_pkg::*;
(
  // clock and reset
  input  wire logic                     ref_clk_i,
  input  wire logic                     rst_b_i,
  input  wire logic                     clk_en_i,
  // packet link
  rxrtp_if.device                       link,
  // connection configuration
  input  wire logic                     rtp_mode_i,
  input  wire logic                     checksum_error_report_en_i,
  input  wire logic                     checksum_error_discard_en_i,
  input  wire logic                     seq_loss_report_en_i,
  input  wire logic [24:0]              table_base_i,
  input  wire logic                     conn_clear_i,
  // table memory write port
  input  wire logic                     tbl_we_i,
  input  wire logic [RXRTP_IDX_W-1:0]   tbl_addr_i,
  input  wire logic [RXRTP_SPLIT_W-1:0] tbl_data_i,
  // split entry write port
  input  wire logic                     split_we_i,
  input  wire logic [RXRTP_SPLIT_W-1:0] split_addr_i,
  input  wire logic                     split_ij_i,
  input  wire logic                     split_rpt_i,
  input  wire logic [2:0]               split_type_i,
  input  wire logic [3:0]               split_vc_i,
  input  wire logic [26:0]              split_chan_ptr_i,
  // connection state
  output logic                          conn_init_o,
  output logic                          jitter_initialized_o,
  output logic [RXRTP_SEQ_W-1:0]        last_seq_o,
  output logic [RXRTP_TS_W-1:0]         last_rtp_ts_o,
  output logic [RXRTP_LOCAL_TS_W-1:0]   last_local_ts_o,
  output logic [RXRTP_JIT_W-1:0]        jitter_o,
  output logic [RXRTP_PKT_CNT_W-1:0]    pkt_cnt_o,
  output logic [RXRTP_OCT_CNT_W-1:0]    oct_cnt_o,
  // table address and routing result
  output logic [RXRTP_ADDR_W-1:0]       tbl_byte_addr_o,
  output logic                          route_valid_o,
  output rxrtp_route_e                  route_o,
  output rxrtp_vc_e                     vc_o,
  output logic [RXRTP_ADDR_W-1:0]       chan_addr_o,
  // event report
  output logic                          ev_valid_o,
  output logic [RXRTP_EV_W-1:0]         ev_flags_o,
  output logic [RXRTP_IDX_W-1:0]        ev_index_o,
  output logic [RXRTP_SEQ_W-1:0]        ev_prev_seq_o,
  output logic [RXRTP_SEQ_W-1:0]        ev_cur_seq_o,
  output logic [RXRTP_LOCAL_TS_W-1:0]   ev_local_ts_o
);
  rxrtp_state_e                 state_r;
  logic [RXRTP_SPLIT_W-1:0]     tbl_mem [0:255];
  logic [36:0]                  split_mem [0:RXRTP_NSPLIT-1];
  logic                         csum_bad_r;
  logic                         marker_r;
  logic [6:0]                   pt_r;
  logic [RXRTP_SEQ_W-1:0]       seq_r;
  logic [RXRTP_TS_W-1:0]        rtp_ts_r;
  logic [15:0]                  udp_len_r;
  logic [RXRTP_LOCAL_TS_W-1:0]  local_ts_r;
  logic [RXRTP_IDX_W-1:0]       idx_r;
  logic [RXRTP_SPLIT_W-1:0]     split_sel_r;
  logic [36:0]                  entry;
  logic [15:0]                  pay_len;
  logic [RXRTP_IDX_W-1:0]       idx_nxt;
  logic                         entry_ij;
  logic                         entry_rpt;
  rxrtp_route_e                 dec_route;
  rxrtp_vc_e                    dec_vc;
  logic signed [RXRTP_TS_W:0]   d_diff;
  logic [RXRTP_TS_W-1:0]        d_abs;
  logic [RXRTP_JIT_W-1:0]       jit_nxt;
  logic                         accept;
  logic                         seq_gap;

  assign accept         = link.pkt_valid && link.pkt_ready;
  assign link.pkt_ready = (state_r == RXRTP_ST_IDLE) && clk_en_i;
  assign entry          = split_mem[split_sel_r];
  assign entry_ij       = entry[36];
  assign entry_rpt      = entry[35];
  assign pay_len        = link.pkt_udp_len - RXRTP_UDP_HDR_LEN;
  assign seq_gap        = conn_init_o && (seq_r != last_seq_o + 16'h0001);

  // index: marker and payload type, or capped length
  always_comb begin
    if (rtp_mode_i) begin                                       // RQ21
      idx_nxt = {link.pkt_marker, link.pkt_payload_type};       // RQ18
    end else if (pay_len >= RXRTP_IDX_CAP) begin
      idx_nxt = RXRTP_IDX_CAP[7:0];                             // RQ19
    end else begin
      idx_nxt = pay_len[7:0];
    end
  end

  // jitter: transit difference, one local tick per frame
  always_comb begin
    d_diff  = $signed({1'b0, rtp_ts_r - last_rtp_ts_o})
            - $signed({1'b0, 8'h00, local_ts_r - last_local_ts_o});
    d_abs   = d_diff[RXRTP_TS_W] ? RXRTP_TS_W'(-d_diff) : d_diff[RXRTP_TS_W-1:0];
    jit_nxt = jitter_o - (jitter_o >> RXRTP_JIT_SHIFT)          // RQ22
            + ((d_abs << RXRTP_JIT_FRAC_W) >> RXRTP_JIT_SHIFT); // RQ8
  end

  rxrtp_split_decode u_dec (
    .split_type_i        (entry[34:32]),
    .voice_coding_info_i (entry[31:28]),
    .route_o             (dec_route),
    .vc_o                (dec_vc)
  );

  // software-loaded table and split entries
  always_ff @(posedge ref_clk_i) begin
    if (clk_en_i && tbl_we_i) begin
      tbl_mem[tbl_addr_i] <= tbl_data_i;
    end
    if (clk_en_i && split_we_i) begin
      split_mem[split_addr_i] <= {split_ij_i, split_rpt_i, split_type_i, split_vc_i,
                                  split_chan_ptr_i[26:0], 1'b0};
    end
  end

  // sequencer: capture, table read, split decode, done
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r <= RXRTP_ST_IDLE;
    end else if (clk_en_i) begin
      case (state_r)
        RXRTP_ST_IDLE: begin
          if (accept) state_r <= RXRTP_ST_TABLE;
        end
        RXRTP_ST_TABLE: begin
          if (csum_bad_r && checksum_error_discard_en_i) state_r <= RXRTP_ST_DONE;
          else state_r <= RXRTP_ST_SPLIT;
        end
        RXRTP_ST_SPLIT: state_r <= RXRTP_ST_DONE;
        RXRTP_ST_DONE:  state_r <= RXRTP_ST_IDLE;
        default:        state_r <= RXRTP_ST_IDLE;
      endcase
    end
  end

  // packet capture and table lookup
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      csum_bad_r  <= 1'b0;
      marker_r    <= 1'b0;
      pt_r        <= 7'h00;
      seq_r       <= 16'h0000;
      rtp_ts_r    <= 32'h0000_0000;
      udp_len_r   <= 16'h0000;
      local_ts_r  <= 24'h00_0000;
      idx_r       <= 8'h00;
      split_sel_r <= 4'h0;
    end else if (clk_en_i) begin
      if (accept) begin
        csum_bad_r <= link.pkt_csum_bad;
        marker_r   <= link.pkt_marker;
        pt_r       <= link.pkt_payload_type;
        seq_r      <= link.pkt_seq;
        rtp_ts_r   <= link.pkt_rtp_ts;
        udp_len_r  <= link.pkt_udp_len;
        local_ts_r <= link.pkt_local_ts[RXRTP_LOCAL_TS_W-1:0];    // RQ6
        idx_r      <= idx_nxt;
      end
      if (state_r == RXRTP_ST_TABLE) begin
        split_sel_r <= tbl_mem[idx_r];                          // RQ17
      end
    end
  end

  // connection structure update
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      conn_init_o          <= 1'b0;
      jitter_initialized_o <= 1'b0;
      last_seq_o           <= 16'h0000;
      last_rtp_ts_o        <= 32'h0000_0000;
      last_local_ts_o      <= 24'h00_0000;
      jitter_o             <= 32'h0000_0000;
      pkt_cnt_o            <= 16'h0000;
      oct_cnt_o            <= 32'h0000_0000;
    end else if (clk_en_i) begin
      if (conn_clear_i) begin
        conn_init_o          <= 1'b0;
        jitter_initialized_o <= 1'b0;
      end
      if (state_r == RXRTP_ST_SPLIT) begin
        conn_init_o <= 1'b1;                                    // RQ5
        pkt_cnt_o   <= pkt_cnt_o + 16'h0001;                    // RQ9 RQ24
        oct_cnt_o   <= oct_cnt_o + {16'h0000, udp_len_r - RXRTP_UDP_HDR_LEN}; // RQ10
        if (entry_ij) begin                                     // RQ11
          jitter_initialized_o <= 1'b1;                         // RQ4
          last_seq_o           <= seq_r;                        // RQ7
          last_rtp_ts_o        <= rtp_ts_r;                     // RQ7
          last_local_ts_o      <= local_ts_r;                   // RQ6
          if (jitter_initialized_o) jitter_o <= jit_nxt;        // RQ22
        end
      end
    end
  end

  // routing and event reports
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tbl_byte_addr_o <= 32'h0000_0000;
      route_valid_o   <= 1'b0;
      route_o         <= RXRTP_RT_DEL;
      vc_o            <= RXRTP_VC_PCM;
      chan_addr_o     <= 32'h0000_0000;
      ev_valid_o      <= 1'b0;
      ev_flags_o      <= 4'h0;
      ev_index_o      <= 8'h00;
      ev_prev_seq_o   <= 16'h0000;
      ev_cur_seq_o    <= 16'h0000;
      ev_local_ts_o   <= 24'h00_0000;
    end else if (clk_en_i) begin
      route_valid_o <= 1'b0;
      ev_valid_o    <= 1'b0;
      if (state_r == RXRTP_ST_TABLE) begin
        tbl_byte_addr_o <= {table_base_i, idx_r[7:1]};          // RQ20 RQ16
        // a discard still reports
        if (csum_bad_r && checksum_error_discard_en_i) begin
          ev_valid_o    <= checksum_error_report_en_i;          // RQ1
          ev_flags_o    <= 4'h1 << RXRTP_EV_UCE;
          ev_index_o    <= idx_r;
          ev_cur_seq_o  <= seq_r;
          ev_local_ts_o <= local_ts_r;
        end
      end
      if (state_r == RXRTP_ST_SPLIT) begin
        route_valid_o <= 1'b1;
        route_o       <= dec_route;                             // RQ13
        vc_o          <= dec_vc;                                // RQ14
        // delete yields no channel address
        chan_addr_o   <= (dec_route == RXRTP_RT_DEL) ? 32'h0000_0000
                         : {entry[27:1], 5'h00};                // RQ15 RQ23
        ev_flags_o[RXRTP_EV_INIT] <= !conn_init_o;
        ev_flags_o[RXRTP_EV_LOSS] <= seq_loss_report_en_i && entry_ij && seq_gap; // RQ2 RQ3
        ev_flags_o[RXRTP_EV_RPT]  <= entry_rpt;                 // RQ12
        ev_flags_o[RXRTP_EV_UCE]  <= checksum_error_report_en_i && csum_bad_r; // RQ1
        ev_valid_o    <= !conn_init_o || (seq_loss_report_en_i && entry_ij && seq_gap)
                         || entry_rpt || (checksum_error_report_en_i && csum_bad_r);
        ev_index_o    <= idx_r;
        ev_prev_seq_o <= last_seq_o;
        ev_cur_seq_o  <= seq_r;
        ev_local_ts_o <= local_ts_r;
      end
    end
  end
endmodule

// >>> hdl/rxrtp_pkg.sv
// Notes on behaviour
// RQ1 - checksum report flag posts event on bad checksum
// RQ2 - loss report flag posts event on sequence gap
// RQ3 - software keeps loss report off for UDP
// RQ4 - jitter initialized set by first jitter packet
// RQ5 - connection initialized set by first packet
// RQ6 - store low 24 bits of local timestamp
// RQ7 - hold last sequence number and RTP timestamp
// RQ8 - jitter kept as integer plus fraction frames
// RQ9 - packet counter increments per valid packet
// RQ10 - octet counter adds UDP length minus eight
// RQ11 - only include-jitter entries update jitter fields
// RQ12 - report flag posts marker and payload type
// RQ13 - decode three-bit split type
// RQ14 - decode four-bit voice coding info
// RQ15 - channel structure address in 32-byte units
// RQ16 - table is 128-byte aligned block
// RQ17 - table entry selects one of sixteen splits
// RQ18 - RTP index is marker then payload type
// RQ19 - UDP index is payload length capped 255
// RQ20 - table base pointer in 128-byte units
// RQ21 - RTP flag selects indexing mode
// RQ22 - jitter update fifteen sixteenths plus one sixteenth
// RQ23 - delete type discards without channel read
// RQ24 - counters wrap; code 1010 needs confirmation
package rxrtp_pkg;
  localparam int unsigned RXRTP_LOCAL_TS_W   = 24;
  localparam int unsigned RXRTP_SEQ_W        = 16;
  localparam int unsigned RXRTP_TS_W         = 32;
  localparam int unsigned RXRTP_PKT_CNT_W    = 16;
  localparam int unsigned RXRTP_OCT_CNT_W    = 32;
  localparam int unsigned RXRTP_JIT_FRAC_W   = 4;
  localparam int unsigned RXRTP_JIT_W        = 32;
  localparam int unsigned RXRTP_IDX_W        = 8;
  localparam int unsigned RXRTP_SPLIT_W      = 4;
  localparam int unsigned RXRTP_NSPLIT       = 16;
  localparam int unsigned RXRTP_ADDR_W       = 32;
  localparam int unsigned RXRTP_TBL_SHIFT    = 7;  // 128-byte units
  localparam int unsigned RXRTP_CHAN_SHIFT   = 5;  // 32-byte units
  localparam logic [15:0] RXRTP_UDP_HDR_LEN  = 16'h0008;
  localparam logic [15:0] RXRTP_IDX_CAP      = 16'h00FF;
  localparam int unsigned RXRTP_JIT_SHIFT    = 4;  // 1/16 weight
  // split types
  localparam logic [2:0] RXRTP_TYPE_PCM  = 3'h0;
  localparam logic [2:0] RXRTP_TYPE_HDLC = 3'h1;
  localparam logic [2:0] RXRTP_TYPE_CPU  = 3'h2;
  localparam logic [2:0] RXRTP_TYPE_DEL  = 3'h7;
  // routing result
  typedef enum logic [2:0] {
    RXRTP_RT_PCM  = 3'b000,
    RXRTP_RT_HDLC = 3'b001,
    RXRTP_RT_CPU  = 3'b010,
    RXRTP_RT_DEL  = 3'b011,
    RXRTP_RT_RSVD = 3'b100
  } rxrtp_route_e;
  // voice coding classes
  typedef enum logic [2:0] {
    RXRTP_VC_PCM   = 3'b000,
    RXRTP_VC_ADPCM = 3'b001,
    RXRTP_VC_CNI   = 3'b010,
    RXRTP_VC_LAW   = 3'b011,
    RXRTP_VC_CNE   = 3'b100,
    RXRTP_VC_RSVD  = 3'b101
  } rxrtp_vc_e;
  // event bits
  localparam int unsigned RXRTP_EV_INIT = 0;
  localparam int unsigned RXRTP_EV_LOSS = 1;
  localparam int unsigned RXRTP_EV_RPT  = 2;
  localparam int unsigned RXRTP_EV_UCE  = 3;
  localparam int unsigned RXRTP_EV_W    = 4;
  typedef enum logic [1:0] {
    RXRTP_ST_IDLE  = 2'b00,
    RXRTP_ST_TABLE = 2'b01,
    RXRTP_ST_SPLIT = 2'b10,
    RXRTP_ST_DONE  = 2'b11
  } rxrtp_state_e;
endpackage

// >>> hdl/rxrtp_if.sv
`timescale 1ns/1ns
// descriptors from upstream to classifier
interface rxrtp_if;
  import rxrtp_pkg::*;
  logic                        pkt_valid;
  logic                        pkt_ready;
  logic                        pkt_csum_bad;
  logic                        pkt_marker;
  logic [6:0]                  pkt_payload_type;
  logic [RXRTP_SEQ_W-1:0]      pkt_seq;
  logic [RXRTP_TS_W-1:0]       pkt_rtp_ts;
  logic [15:0]                 pkt_udp_len;
  logic [RXRTP_TS_W-1:0]       pkt_local_ts;
  modport upstream (output pkt_valid, pkt_csum_bad, pkt_marker, pkt_payload_type, pkt_seq,
                    pkt_rtp_ts, pkt_udp_len, pkt_local_ts, input pkt_ready);
  modport device   (input pkt_valid, pkt_csum_bad, pkt_marker, pkt_payload_type, pkt_seq,
                    pkt_rtp_ts, pkt_udp_len, pkt_local_ts, output pkt_ready);
endinterface

// >>> hdl/rxrtp_split_decode.sv
`timescale 1ns/1ns
// decodes one split entry into route and voice coding class
module rxrtp_split_decode
  import rxrtp_pkg::*;
(
  // split entry fields
  input  wire logic [2:0] split_type_i,
  input  wire logic [3:0] voice_coding_info_i,
  // decoded
  output rxrtp_route_e    route_o,
  output rxrtp_vc_e       vc_o
);
  // type decode
  always_comb begin
    case (split_type_i)
      RXRTP_TYPE_PCM:  route_o = RXRTP_RT_PCM;  // RQ13
      RXRTP_TYPE_HDLC: route_o = RXRTP_RT_HDLC; // RQ13
      RXRTP_TYPE_CPU:  route_o = RXRTP_RT_CPU;  // RQ13
      RXRTP_TYPE_DEL:  route_o = RXRTP_RT_DEL;  // RQ23
      default:         route_o = RXRTP_RT_RSVD;
    endcase
  end
  // coding decode; 1010 taken as law conversion
  always_comb begin
    case (voice_coding_info_i)
      4'h0:                   vc_o = RXRTP_VC_PCM;   // RQ14
      4'h1, 4'h2, 4'h3, 4'h4: vc_o = RXRTP_VC_ADPCM; // RQ14
      4'h5:                   vc_o = RXRTP_VC_CNI;   // RQ14
      4'h8, 4'h9, 4'hA, 4'hB: vc_o = RXRTP_VC_LAW;   // RQ24
      4'hC:                   vc_o = RXRTP_VC_CNE;   // RQ14
      default:                vc_o = RXRTP_VC_RSVD;
    endcase
  end
endmodule

// >>> hdl/rxrtp_upstream.sv
`timescale 1ns/1ns
// upstream end: holds one descriptor until taken
module rxrtp_upstream
  import rxrtp_pkg::*;
(
  // clock and reset
  input  wire logic                   ref_clk_i,
  input  wire logic                   rst_b_i,
  input  wire logic                   clk_en_i,
  // user side
  input  wire logic                   send_i,
  input  wire logic                   csum_bad_i,
  input  wire logic                   marker_i,
  input  wire logic [6:0]             payload_type_i,
  input  wire logic [RXRTP_SEQ_W-1:0] seq_i,
  input  wire logic [RXRTP_TS_W-1:0]  rtp_ts_i,
  input  wire logic [15:0]            udp_len_i,
  input  wire logic [RXRTP_TS_W-1:0]  local_ts_i,
  output logic                        busy_o,
  // link
  rxrtp_if.upstream                   link
);
  // send ignored while pending
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_o                <= 1'b0;
      link.pkt_valid        <= 1'b0;
      link.pkt_csum_bad     <= 1'b0;
      link.pkt_marker       <= 1'b0;
      link.pkt_payload_type <= 7'h00;
      link.pkt_seq          <= 16'h0000;
      link.pkt_rtp_ts       <= 32'h0000_0000;
      link.pkt_udp_len      <= 16'h0000;
      link.pkt_local_ts     <= 32'h0000_0000;
    end else if (clk_en_i) begin
      if (link.pkt_valid && link.pkt_ready) begin
        link.pkt_valid <= 1'b0;
        busy_o         <= 1'b0;
      end else if (send_i && !link.pkt_valid) begin
        link.pkt_valid        <= 1'b1;
        busy_o                <= 1'b1;
        link.pkt_csum_bad     <= csum_bad_i;
        link.pkt_marker       <= marker_i;
        link.pkt_payload_type <= payload_type_i;
        link.pkt_seq          <= seq_i;
        link.pkt_rtp_ts       <= rtp_ts_i;
        link.pkt_udp_len      <= udp_len_i;
        link.pkt_local_ts     <= local_ts_i;
      end
    end
  end
endmodule

// >>> verif/rxrtp_sva.sv
`timescale 1ns/1ns
// link and result checks
module rxrtp_sva
  import rxrtp_pkg::*;
(
  // clock, reset and link
  input wire logic         ref_clk_i,
  input wire logic         rst_b_i,
  input wire logic         pkt_valid,
  input wire logic         pkt_ready,
  input wire logic         pkt_csum_bad,
  input wire logic         pkt_marker,
  input wire logic [6:0]   pkt_payload_type,
  input wire logic [15:0]  pkt_udp_len,
  input wire logic [31:0]  pkt_local_ts,
  // configuration
  input wire logic         rtp_mode_i,
  input wire logic         checksum_error_report_en_i,
  input wire logic         checksum_error_discard_en_i,
  input wire logic [24:0]  table_base_i,
  // results
  input wire logic         conn_init_o,
  input wire logic [15:0]  pkt_cnt_o,
  input wire logic [31:0]  oct_cnt_o,
  input wire logic [31:0]  tbl_byte_addr_o,
  input wire logic         route_valid_o,
  input wire rxrtp_route_e route_o,
  input wire logic [31:0]  chan_addr_o,
  input wire logic         ev_valid_o,
  input wire logic [3:0]   ev_flags_o,
  input wire logic [23:0]  ev_local_ts_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  logic        take;
  logic [15:0] pay;
  logic [7:0]  idx;
  logic [31:0] addr_r;
  logic [15:0] pay_r;
  logic [23:0] ts_r;
  assign take = pkt_valid && pkt_ready;
  assign pay  = pkt_udp_len - RXRTP_UDP_HDR_LEN;
  // udp lengths cap at 255
  assign idx  = rtp_mode_i ? {pkt_marker, pkt_payload_type} :
                (pay > RXRTP_IDX_CAP) ? 8'hff : pay[7:0];
  // latch what the take implies
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      addr_r <= '0;
      pay_r  <= '0;
      ts_r   <= '0;
    end else if (take) begin
      addr_r <= {table_base_i, idx[7:1]};
      pay_r  <= pay;
      ts_r   <= pkt_local_ts[23:0];
    end
  end
  chk_route_lat: assert property (take && !(pkt_csum_bad && checksum_error_discard_en_i)
    |-> ##[3:4] route_valid_o) else $error("route late");
  chk_pkt_count: assert property (route_valid_o
    |-> pkt_cnt_o == 16'($past(pkt_cnt_o) + 16'h0001)) else $error("pkt count");
  chk_oct_count: assert property (route_valid_o
    |-> oct_cnt_o == 32'($past(oct_cnt_o) + {16'h0000, pay_r})) else $error("oct count");
  chk_init_flag: assert property (route_valid_o |-> conn_init_o)
    else $error("init flag");
  chk_csum_event: assert property (take && pkt_csum_bad && checksum_error_report_en_i
    |-> ##[2:4] (ev_valid_o && ev_flags_o[RXRTP_EV_UCE])) else $error("csum event");
  chk_table_addr: assert property (route_valid_o |-> tbl_byte_addr_o == addr_r)
    else $error("table addr");
  chk_event_ts: assert property (ev_valid_o |-> ev_local_ts_o == ts_r)
    else $error("event ts");
  chk_delete_addr: assert property (route_valid_o && route_o == RXRTP_RT_DEL
    |-> chan_addr_o == '0) else $error("delete addr");
endmodule

// >>> verif/tb_top.sv
`timescale 1ns/1ns
// upstream end feeds the classifier
module tb_top;
  import rxrtp_pkg::*;
  logic         ref_clk_i, rst_b_i, send, csum, mark, rtp_mode, rpt_en, disc_en, loss_en, clr;
  logic         tbl_we, split_we, s_ij, s_rpt, conn_init, jit_init, rv, evv, busy, got_rt, got_ev;
  logic [6:0]   pt;
  logic [15:0]  seq, len, last_seq, pcnt, evp, evc, ecnt;
  logic [31:0]  rts, lts, ocnt, tba, chan, eoct;
  logic [7:0]   tbl_a, evi;
  logic [3:0]   tbl_d, s_a, s_vc, evf;
  logic [2:0]   s_ty;
  logic [26:0]  s_ptr;
  logic [23:0]  evts;
  rxrtp_route_e route;
  rxrtp_vc_e    vc;
  int           mismatches, check_count, cycles;
  logic [2:0]   ety [5] = '{3'h0, 3'h1, 3'h2, 3'h7, 3'h3};
  rxrtp_route_e ert [5] = '{RXRTP_RT_PCM, RXRTP_RT_HDLC, RXRTP_RT_CPU, RXRTP_RT_DEL, RXRTP_RT_RSVD};
  logic [15:0]  ulen [3] = '{16'h0107, 16'h0134, 16'h000d};
  logic [7:0]   uidx [3] = '{8'hff, 8'hff, 8'h05};
  rxrtp_if rxrtp_if_inst();
  rxrtp_upstream rxrtp_upstream_inst(.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .clk_en_i(1'b1),
    .send_i(send), .csum_bad_i(csum), .marker_i(mark), .payload_type_i(pt), .seq_i(seq),
    .rtp_ts_i(rts), .udp_len_i(len), .local_ts_i(lts), .busy_o(busy),
    .link(rxrtp_if_inst.upstream));
  rxrtp_device rxrtp_device_inst(.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .clk_en_i(1'b1),
    .link(rxrtp_if_inst.device), .rtp_mode_i(rtp_mode), .checksum_error_report_en_i(rpt_en),
    .checksum_error_discard_en_i(disc_en), .seq_loss_report_en_i(loss_en),
    .table_base_i(25'h00_0123), .conn_clear_i(clr), .tbl_we_i(tbl_we), .tbl_addr_i(tbl_a),
    .tbl_data_i(tbl_d), .split_we_i(split_we), .split_addr_i(s_a), .split_ij_i(s_ij),
    .split_rpt_i(s_rpt), .split_type_i(s_ty), .split_vc_i(s_vc), .split_chan_ptr_i(s_ptr),
    .conn_init_o(conn_init), .jitter_initialized_o(jit_init), .last_seq_o(last_seq),
    .last_rtp_ts_o(), .last_local_ts_o(), .jitter_o(), .pkt_cnt_o(pcnt), .oct_cnt_o(ocnt),
    .tbl_byte_addr_o(tba), .route_valid_o(rv), .route_o(route), .vc_o(vc), .chan_addr_o(chan),
    .ev_valid_o(evv), .ev_flags_o(evf), .ev_index_o(evi), .ev_prev_seq_o(evp),
    .ev_cur_seq_o(evc), .ev_local_ts_o(evts));
  rxrtp_sva rxrtp_sva_inst(.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .pkt_valid(rxrtp_if_inst.pkt_valid), .pkt_ready(rxrtp_if_inst.pkt_ready),
    .pkt_csum_bad(rxrtp_if_inst.pkt_csum_bad), .pkt_marker(rxrtp_if_inst.pkt_marker),
    .pkt_payload_type(rxrtp_if_inst.pkt_payload_type), .pkt_udp_len(rxrtp_if_inst.pkt_udp_len),
    .pkt_local_ts(rxrtp_if_inst.pkt_local_ts), .rtp_mode_i(rtp_mode),
    .checksum_error_report_en_i(rpt_en), .checksum_error_discard_en_i(disc_en),
    .table_base_i(25'h00_0123), .conn_init_o(conn_init), .pkt_cnt_o(pcnt), .oct_cnt_o(ocnt),
    .tbl_byte_addr_o(tba), .route_valid_o(rv), .route_o(route), .chan_addr_o(chan),
    .ev_valid_o(evv), .ev_flags_o(evf), .ev_local_ts_o(evts));
  always #25 ref_clk_i = ~ref_clk_i;
  // a hang costs a mismatch and ends the run
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tbl_wr(input logic [7:0] a, input logic [3:0] d);
    @(posedge ref_clk_i);
    tbl_we <= 1'b1;
    tbl_a  <= a;
    tbl_d  <= d;
    @(posedge ref_clk_i);
    tbl_we <= 1'b0;
  endtask
  task automatic split_wr(input logic [3:0] a, input logic ij, input logic r, input logic [2:0] t,
                          input logic [3:0] v, input logic [26:0] p);
    @(posedge ref_clk_i);
    split_we <= 1'b1;
    s_a      <= a;
    s_ij     <= ij;
    s_rpt    <= r;
    s_ty     <= t;
    s_vc     <= v;
    s_ptr    <= p;
    @(posedge ref_clk_i);
    split_we <= 1'b0;
  endtask
  // one packet, then watch eight cycles
  task automatic send_pkt(input logic c, input logic m, input logic [6:0] p,
                          input logic [15:0] s, input logic [15:0] l);
    @(posedge ref_clk_i);
    send <= 1'b1;
    csum <= c;
    mark <= m;
    pt   <= p;
    seq  <= s;
    rts  <= {s, 16'h00a0};
    len  <= l;
    lts  <= lts + 32'h0100_0007;
    @(posedge ref_clk_i);
    send   <= 1'b0;
    got_rt = 1'b0;
    got_ev = 1'b0;
    repeat (8) @(negedge ref_clk_i) begin
      if (rv === 1'b1) got_rt = 1'b1;
      if (evv === 1'b1) got_ev = 1'b1;
    end
    if (!(c && disc_en)) begin
      ecnt = ecnt + 16'h0001;
      eoct = eoct + {16'h0000, l} - 32'h0000_0008;
    end
    chk("pkt_cnt", pcnt, ecnt);
    chk("oct_cnt", ocnt, eoct);
  endtask
  function automatic rxrtp_vc_e vc_exp(input logic [3:0] c);
    if (c == 4'h0) return RXRTP_VC_PCM;
    if (c <= 4'h4) return RXRTP_VC_ADPCM;
    if (c == 4'h5) return RXRTP_VC_CNI;
    if (c[3:2] == 2'b10) return RXRTP_VC_LAW;
    if (c == 4'hc) return RXRTP_VC_CNE;
    return RXRTP_VC_RSVD;
  endfunction
  initial begin
    {ref_clk_i, rst_b_i, send, csum, mark, rpt_en, disc_en, loss_en, clr} = '0;
    {tbl_we, split_we, s_ij, s_rpt, pt, seq, len, rts, tbl_a, tbl_d, s_a, s_vc, s_ty} = '0;
    {s_ptr, ecnt, eoct, mismatches, check_count, cycles} = '0;
    lts = 32'hff00_0000;
    rtp_mode = 1'b1;
    repeat (5) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    // each route result; split 0 feeds jitter
    for (int i = 0; i < 5; i++) begin
      tbl_wr({1'b1, 7'(i)}, 4'(i));
      split_wr(4'(i), i == 0, 1'b0, ety[i], 4'h0, 27'h000_0100 + 27'(i));
    end
    for (int i = 0; i < 5; i++) begin
      send_pkt(1'b0, 1'b1, 7'(i), 16'(10 + i), 16'(28 + i));
      chk("route", route, ert[i]);
      chk("chan", chan, (i == 3) ? 32'h0000_0000 : 32'h0000_2000 + 32'(i * 32));
      chk("init", conn_init, 1'b1);
    end
    $display("split type test done");
    for (int c = 0; c < 16; c++) begin
      split_wr(4'h0, 1'b1, 1'b0, 3'h0, 4'(c), 27'h000_0100);
      send_pkt(1'b0, 1'b1, 7'h00, 16'(20 + c), 16'h0020);
      chk("vc", vc, vc_exp(4'(c)));
      chk("last_seq", last_seq, 16'(20 + c));
    end
    send_pkt(1'b0, 1'b1, 7'h01, 16'h0100, 16'h0020);
    chk("last_seq", last_seq, 16'h0023);
    $display("voice coding test done");
    loss_en <= 1'b1;
    send_pkt(1'b0, 1'b1, 7'h00, 16'h0028, 16'h0020);
    chk("loss_ev", {got_ev, evf[RXRTP_EV_LOSS], evp, evc}, {2'b11, 16'h0023, 16'h0028});
    send_pkt(1'b0, 1'b1, 7'h00, 16'h0029, 16'h0020);
    chk("no_loss", got_ev, 1'b0);
    split_wr(4'h2, 1'b0, 1'b1, 3'h2, 4'h0, 27'h000_0102);
    send_pkt(1'b0, 1'b1, 7'h02, 16'h0030, 16'h0020);
    chk("rpt_ev", {got_ev, evf[RXRTP_EV_RPT], evi}, {2'b11, 8'h82});
    rpt_en <= 1'b1;
    send_pkt(1'b1, 1'b1, 7'h01, 16'h0031, 16'h0020);
    chk("csum_ev", {got_ev, evf[RXRTP_EV_UCE], got_rt}, 3'b111);
    disc_en <= 1'b1;
    send_pkt(1'b1, 1'b1, 7'h01, 16'h0032, 16'h0020);
    chk("csum_drop", {got_ev, evf[RXRTP_EV_UCE], got_rt}, 3'b110);
    disc_en <= 1'b0;
    $display("event test done");
    rtp_mode <= 1'b0;
    loss_en  <= 1'b0;
    tbl_wr(8'hff, 4'h2);
    tbl_wr(8'h05, 4'h1);
    for (int i = 0; i < 3; i++) begin
      send_pkt(1'b0, 1'b0, 7'h00, 16'h0000, ulen[i]);
      chk("udp_route", route, (i == 2) ? RXRTP_RT_HDLC : RXRTP_RT_CPU);
      chk("udp_addr", tba, {25'h00_0123, uidx[i][7:1]});
    end
    $display("udp index test done");
    rtp_mode <= 1'b1;
    @(posedge ref_clk_i);
    clr <= 1'b1;
    @(posedge ref_clk_i);
    clr <= 1'b0;
    @(negedge ref_clk_i);
    chk("clr_flags", {conn_init, jit_init}, 2'b00);
    send_pkt(1'b0, 1'b1, 7'h01, 16'h0040, 16'h0020);
    chk("init_ev", {got_ev, evf[RXRTP_EV_INIT], conn_init, jit_init}, 4'b1110);
    send_pkt(1'b0, 1'b1, 7'h00, 16'h0041, 16'h0020);
    chk("jit_init", jit_init, 1'b1);
    $display("reinit test done");
    report_and_stop();
  end
endmodule
